/* File: design/aes_card_bridge.sv */
// Function
// - pack four receiver I2S pairs into octal streams
// - unpack host octal stream into four transmitter I2S
// - load configuration, signal done before bus access
// - read-only fixed identity register at zero
// - host reads identity then programs the card
// - receiver and transmitter chip windows decoded
// - offset 0x60 selects all four transmitters
// - control bits 7:6 pick slot clock source
// - control bits 5:4 pick preview clock source
// - source code n selects input n+1
// - bits 3 and 2 enable clock outputs
// - bit 1 selects double-speed rates
// - bit 0 selects test loopback
// - loopback returns inputs and host octal data
// - lock bits seek mode and receiver clock drive
// - host lock sequence waits at least 10 ms
// - octal output selects and encoded input group
`include "aes_card_cfg.svh"

module aes_card_bridge (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // host i/o bus
    input  wire logic       io_cs_n,
    input  wire logic       io_rd_n,
    input  wire logic       io_wr_n,
    input  wire logic [8:0] io_addr,
    input  wire logic [7:0] io_data_in,
    output logic      [7:0] io_data_out,
    output logic            io_data_oe,
    // receiver and transmitter chip access
    output logic      [3:0] rx_cs_n,
    output logic      [3:0] tx_cs_n,
    output logic            chip_rd_n,
    output logic            chip_wr_n,
    // serial configuration memory
    output logic            serial_config_memory_clk,
    input  wire logic       serial_config_memory_data,
    output logic            config_done,
    // word clocks and lock control
    input  wire logic [3:0] rx_word_clk,
    output logic            slot_word_clk,
    output logic            preview_word_clk,
    output logic            double_speed,
    output logic            seek_mode,
    output logic            drive_rx_clocks,
    // link side, 256 fs
    input  wire logic       link_clk,
    input  wire logic       link_fsync,
    input  wire logic [2:0] octal_in,
    output logic      [2:0] octal_out,
    output logic      [2:0] octal_out_oe,
    output logic            i2s_bclk,
    output logic            i2s_lrck,
    input  wire logic [3:0] rx_sdata,
    output logic      [3:0] tx_sdata
);
    // ---------------- configuration load ----------------
    cfg_load_if cfg ();

    cfg_loader u_loader (
        .ref_clk (ref_clk),
        .rst     (rst),
        .cfg     (cfg.loader)
    );

    assign cfg.mem_data             = serial_config_memory_data;
    assign serial_config_memory_clk = cfg.mem_clk;
    assign config_done              = cfg.done;

    // ---------------- host bus ----------------
    logic [1:0] strobe_s;

    bit_sync #(.W(2)) u_strobe_sync (
        .clk (ref_clk),
        .rst (rst),
        .d   ({~io_cs_n & ~io_rd_n, ~io_cs_n & ~io_wr_n}),
        .q   (strobe_s)
    );

    aes_card_pkg::bus_state_t bus_state_reg;
    aes_card_pkg::reg_byte_t  card_control_reg;
    aes_card_pkg::reg_byte_t  word_clock_lock_control_reg;
    aes_card_pkg::reg_byte_t  octal_group_select_reg;
    logic [8:0] addr_reg;
    logic [7:0] wdata_reg;
    logic       is_wr_reg;

    wire logic rd_s     = strobe_s[1];
    wire logic wr_s     = strobe_s[0];
    wire logic start    = (bus_state_reg == aes_card_pkg::BUS_IDLE) && cfg.done && (rd_s || wr_s);
    wire logic released = !rd_s && !wr_s;
    wire logic active   = bus_state_reg != aes_card_pkg::BUS_IDLE;
    wire logic apply    = bus_state_reg == aes_card_pkg::BUS_APPLY;

    wire logic [8:0] win       = {addr_reg[8:`WIN_LSB], 5'h00};
    wire logic       hit_id    = win == `OFS_ID;
    wire logic       hit_ctrl  = win == `OFS_CTRL;
    wire logic       hit_lock  = win == `OFS_LOCK;
    wire logic       hit_txall = win == `OFS_TX_ALL;
    wire logic       hit_oct   = win == `OFS_OCT_SEL;
    wire logic       hit_rx    = (win >= `OFS_RX_BASE) && (win < `OFS_TX_BASE);
    wire logic       hit_tx    = (win >= `OFS_TX_BASE) && (win <= `OFS_TOP);
    wire logic [1:0] chip_idx  = addr_reg[6:5];
    wire logic       hit_chip  = hit_rx || hit_tx || hit_txall;

    function automatic logic [3:0] one_hot(input logic [1:0] idx);
        one_hot = 4'h1 << idx;
    endfunction

    wire logic [3:0] rx_sel   = hit_rx ? one_hot(chip_idx) : 4'h0;
    wire logic [3:0] tx_sel   = hit_txall ? 4'hf : (hit_tx ? one_hot(chip_idx) : 4'h0);
    wire logic       keep     = active && !(bus_state_reg == aes_card_pkg::BUS_HOLD && released);

    // unmapped windows read back as zero
    wire logic [7:0] rdata_mux =
        hit_id   ? `BOARD_ID_VALUE :
        hit_ctrl ? card_control_reg :
        hit_lock ? (word_clock_lock_control_reg & `LOCK_MASK) :
        hit_oct  ? (octal_group_select_reg & `OCT_MASK) :
                   8'h00;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            bus_state_reg <= aes_card_pkg::BUS_IDLE;
            addr_reg      <= 9'h000;
            wdata_reg     <= 8'h00;
            is_wr_reg     <= 1'b0;
        end
        else
        begin
            unique case (bus_state_reg)
                aes_card_pkg::BUS_IDLE:
                begin
                    // pins are settled once the strobe clears the sync
                    if (start)
                    begin
                        addr_reg      <= io_addr;
                        wdata_reg     <= io_data_in;
                        is_wr_reg     <= wr_s;
                        bus_state_reg <= aes_card_pkg::BUS_APPLY;
                    end
                end
                aes_card_pkg::BUS_APPLY:
                begin
                    bus_state_reg <= aes_card_pkg::BUS_HOLD;
                end
                aes_card_pkg::BUS_HOLD:
                begin
                    if (released)
                        bus_state_reg <= aes_card_pkg::BUS_IDLE;
                end
            endcase
        end
    end

    // writes to the identity window fall through untouched
    wire logic wr_go = apply && is_wr_reg;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            card_control_reg            <= `CTRL_RESET;
            word_clock_lock_control_reg <= `LOCK_RESET;
            octal_group_select_reg      <= `OCT_RESET;
        end
        else if (wr_go)
        begin
            if (hit_ctrl)
                card_control_reg <= wdata_reg;
            if (hit_lock)
                word_clock_lock_control_reg <= wdata_reg & `LOCK_MASK;
            if (hit_oct)
                octal_group_select_reg <= wdata_reg & `OCT_MASK;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            io_data_out <= 8'h00;
            io_data_oe  <= 1'b0;
            rx_cs_n     <= 4'hf;
            tx_cs_n     <= 4'hf;
            chip_rd_n   <= 1'b1;
            chip_wr_n   <= 1'b1;
        end
        else
        begin
            io_data_out <= (apply && !is_wr_reg) ? rdata_mux : io_data_out;
            // chips drive the data bus in their own windows
            io_data_oe  <= keep && !is_wr_reg && !hit_chip;
            rx_cs_n     <= keep ? ~rx_sel : 4'hf;
            tx_cs_n     <= keep ? ~tx_sel : 4'hf;
            chip_rd_n   <= !(keep && hit_chip && !is_wr_reg);
            chip_wr_n   <= !(keep && hit_chip && is_wr_reg);
        end
    end

    // ---------------- word clocks and lock ----------------
    logic [3:0] wclk_s;

    bit_sync #(.W(4)) u_wclk_sync (
        .clk (ref_clk),
        .rst (rst),
        .d   (rx_word_clk),
        .q   (wclk_s)
    );

    function automatic logic pick_wclk(input logic [3:0] clks, input logic [1:0] code);
        pick_wclk = clks[code];
    endfunction

    wire logic [1:0] slot_code = card_control_reg[`CTRL_SLOT_SRC_HI:`CTRL_SLOT_SRC_LO];
    wire logic [1:0] prev_code = card_control_reg[`CTRL_PREV_SRC_HI:`CTRL_PREV_SRC_LO];

    // re-sampled word clocks carry up to one ref_clk of jitter
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            slot_word_clk    <= 1'b0;
            preview_word_clk <= 1'b0;
            double_speed     <= 1'b0;
            seek_mode        <= 1'b0;
            drive_rx_clocks  <= 1'b0;
        end
        else
        begin
            slot_word_clk    <= card_control_reg[`CTRL_SLOT_EN] && pick_wclk(wclk_s, slot_code);
            preview_word_clk <= card_control_reg[`CTRL_PREV_EN] && pick_wclk(wclk_s, prev_code);
            double_speed     <= card_control_reg[`CTRL_DOUBLE];
            seek_mode        <= word_clock_lock_control_reg[`LOCK_SEEK];
            drive_rx_clocks  <= word_clock_lock_control_reg[`LOCK_DRIVE];
        end
    end

    // ---------------- link domain ----------------
    logic [1:0] link_rst_pipe;
    wire  logic link_rst = link_rst_pipe[1];

    always_ff @(posedge link_clk or posedge rst)
    begin
        if (rst)
            link_rst_pipe <= 2'b11;
        else
            link_rst_pipe <= {link_rst_pipe[0], 1'b0};
    end

    logic [5:0] link_ctrl;

    bit_sync #(.W(6)) u_ctrl_sync (
        .clk (link_clk),
        .rst (link_rst),
        .d   ({card_control_reg[`CTRL_LOOPBACK],
               octal_group_select_reg[`OCT_OUT_HI:`OCT_OUT_LO],
               octal_group_select_reg[`OCT_IN_HI:`OCT_IN_LO]}),
        .q   (link_ctrl)
    );

    wire logic       loopback = link_ctrl[5];
    wire logic [2:0] out_sel  = link_ctrl[4:2];
    wire logic [1:0] in_sel   = link_ctrl[1:0];

    logic [7:0]   bit_cnt_reg;
    logic [63:0]  rx_shift_reg [4];
    logic [63:0]  rx_word_reg  [4];
    logic [63:0]  tx_shift_reg [4];
    logic [255:0] oct_in_shift_reg;
    logic [255:0] oct_in_frame_reg;
    logic [255:0] oct_out_shift_reg;

    wire logic [7:0] bit_cnt_next = link_fsync ? 8'h00 : bit_cnt_reg + 8'h01;
    wire logic       frame_end    = bit_cnt_reg == `FRAME_LAST;
    wire logic       sample_phase = bit_cnt_reg[1:0] == `BIT_PHASE_SAMPLE;
    wire logic       shift_phase  = bit_cnt_reg[1:0] == `BIT_PHASE_SHIFT;
    wire logic       word_start   = bit_cnt_reg[7:2] == 6'h00;
    // group 3 is unused and reads as silence
    wire logic       oct_in_bit   = (in_sel == `OCT_IN_NONE) ? 1'b0 : octal_in[in_sel];

    wire logic [255:0] rx_frame = {rx_word_reg[0], rx_word_reg[1], rx_word_reg[2], rx_word_reg[3]};
    wire logic [255:0] pack_src = loopback ? oct_in_frame_reg : rx_frame;
    wire logic [255:0] tx_src   = loopback ? rx_frame : oct_in_frame_reg;

    always_ff @(posedge link_clk or posedge link_rst)
    begin
        if (link_rst)
        begin
            bit_cnt_reg <= 8'h00;
            i2s_bclk    <= 1'b0;
            i2s_lrck    <= 1'b0;
        end
        else
        begin
            bit_cnt_reg <= bit_cnt_next;
            i2s_bclk    <= bit_cnt_next[1];
            i2s_lrck    <= bit_cnt_next[7];
        end
    end

    // I2S data trails lrck by one bit, so the right LSB lands in the next frame
    always_ff @(posedge link_clk or posedge link_rst)
    begin
        if (link_rst)
        begin
            for (int k = 0; k < 4; k++)
            begin
                rx_shift_reg[k] <= 64'h0;
                rx_word_reg[k]  <= 64'h0;
                tx_shift_reg[k] <= 64'h0;
            end
            tx_sdata <= 4'h0;
        end
        else
        begin
            for (int k = 0; k < 4; k++)
            begin
                if (sample_phase)
                begin
                    rx_shift_reg[k] <= {rx_shift_reg[k][62:0], rx_sdata[k]};
                    if (bit_cnt_reg == `RX_LATCH_CNT)
                        rx_word_reg[k] <= {rx_shift_reg[k][62:0], rx_sdata[k]};
                end
                if (shift_phase)
                begin
                    if (word_start)
                        {tx_sdata[k], tx_shift_reg[k]} <= {tx_src[255 - 64*k -: 64], 1'b0};
                    else
                        {tx_sdata[k], tx_shift_reg[k]} <= {tx_shift_reg[k], 1'b0};
                end
            end
        end
    end

    // channel order on the octal line: rx1 left, rx1 right, ... rx4 right
    always_ff @(posedge link_clk or posedge link_rst)
    begin
        if (link_rst)
        begin
            oct_in_shift_reg  <= 256'h0;
            oct_in_frame_reg  <= 256'h0;
            oct_out_shift_reg <= 256'h0;
            octal_out         <= 3'h0;
            octal_out_oe      <= 3'h0;
        end
        else
        begin
            oct_in_shift_reg <= {oct_in_shift_reg[254:0], oct_in_bit};
            if (frame_end)
            begin
                oct_in_frame_reg  <= {oct_in_shift_reg[254:0], oct_in_bit};
                oct_out_shift_reg <= pack_src;
            end
            else
            begin
                oct_out_shift_reg <= {oct_out_shift_reg[254:0], 1'b0};
            end
            octal_out    <= out_sel & {3{oct_out_shift_reg[255]}};
            octal_out_oe <= out_sel;
        end
    end
endmodule

/* File: design/aes_card_cfg.svh */
`ifndef AES_CARD_CFG_SVH
`define AES_CARD_CFG_SVH

// host bus offsets, decoded on 0x20 windows
`define OFS_ID          9'h000
`define OFS_CTRL        9'h020
`define OFS_LOCK        9'h040
`define OFS_TX_ALL      9'h060
`define OFS_OCT_SEL     9'h080
`define OFS_RX_BASE     9'h100
`define OFS_TX_BASE     9'h180
`define OFS_TOP         9'h1e0
`define WIN_LSB         5

// arbitrary card-type value
`define BOARD_ID_VALUE  8'h5a

// card_control fields
`define CTRL_SLOT_SRC_HI 7
`define CTRL_SLOT_SRC_LO 6
`define CTRL_PREV_SRC_HI 5
`define CTRL_PREV_SRC_LO 4
`define CTRL_SLOT_EN     3
`define CTRL_PREV_EN     2
`define CTRL_DOUBLE      1
`define CTRL_LOOPBACK    0
`define CTRL_RESET       8'h00

// word_clock_lock_control fields
`define LOCK_SEEK        1
`define LOCK_DRIVE       0
`define LOCK_MASK        8'h03
`define LOCK_RESET       8'h00

// octal_group_select fields
`define OCT_OUT_HI       4
`define OCT_OUT_LO       2
`define OCT_IN_HI        1
`define OCT_IN_LO        0
`define OCT_IN_NONE      2'h3
`define OCT_MASK         8'h1f
`define OCT_RESET        8'h00

// octal frame: eight 32-bit slots at 256 fs
`define FRAME_LAST       8'hff
`define RX_LATCH_CNT     8'h02
`define BIT_PHASE_SAMPLE 2'h2
`define BIT_PHASE_SHIFT  2'h3

// serial configuration memory timing
`define REF_CLK_NS       40
`define CFG_CLK_NS       400
`define CFG_HALF_CYCLES  (((`CFG_CLK_NS) / 2) / (`REF_CLK_NS))
`define CFG_BITS         16'd64
`define CFG_SYNC         8'ha5

`endif

/* File: design/aes_card_pkg.sv */
package aes_card_pkg;
    typedef enum logic [1:0] {BUS_IDLE, BUS_APPLY, BUS_HOLD} bus_state_t;
    typedef enum logic       {LOAD_SHIFT, LOAD_DONE} load_state_t;
    typedef logic [7:0] reg_byte_t;
    typedef logic [63:0] stereo_word_t;
endpackage

/* File: design/bit_sync.sv */
module bit_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    wire  logic [W-1:0] differ = s2_reg ^ s3_reg;

    // a bit moves only once the second and third stages agree
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            q      <= '0;
        end
        else
        begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            q      <= (s3_reg & ~differ) | (q & differ);
        end
    end
endmodule

/* File: design/cfg_load_if.sv */
interface cfg_load_if;
    logic mem_clk;
    logic mem_data;
    logic done;
    modport loader (output mem_clk, output done, input mem_data);
    modport user   (input mem_clk, input done, output mem_data);
endinterface

/* File: design/cfg_loader.sv */
module cfg_loader (
    input  wire logic  ref_clk,
    input  wire logic  rst,
    cfg_load_if.loader cfg
);
    aes_card_pkg::load_state_t state_reg;
    logic [15:0] div_reg;
    logic [15:0] bit_cnt_reg;
    logic [7:0]  sync_reg;
    logic        clk_reg;
    logic        done_reg;

    wire logic half_done = div_reg == 16'(`CFG_HALF_CYCLES - 1);
    wire logic rise      = half_done && !clk_reg;
    wire logic last_bit  = bit_cnt_reg == (`CFG_BITS - 16'd1);

    assign cfg.mem_clk = clk_reg;
    assign cfg.done    = done_reg;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg   <= aes_card_pkg::LOAD_SHIFT;
            div_reg     <= 16'h0000;
            bit_cnt_reg <= 16'h0000;
            sync_reg    <= 8'h00;
            clk_reg     <= 1'b0;
            done_reg    <= 1'b0;
        end
        else
        begin
            unique case (state_reg)
                aes_card_pkg::LOAD_SHIFT:
                begin
                    div_reg <= half_done ? 16'h0000 : div_reg + 16'h0001;
                    if (half_done)
                        clk_reg <= !clk_reg;
                    if (rise)
                    begin
                        // leading byte is the image preamble
                        if (bit_cnt_reg < 16'd8)
                            sync_reg <= {sync_reg[6:0], cfg.mem_data};
                        bit_cnt_reg <= last_bit ? 16'h0000 : bit_cnt_reg + 16'h0001;
                        // a bad preamble restarts the whole load
                        if (last_bit && sync_reg == `CFG_SYNC)
                        begin
                            state_reg <= aes_card_pkg::LOAD_DONE;
                            done_reg  <= 1'b1;
                        end
                    end
                end
                aes_card_pkg::LOAD_DONE:
                begin
                    clk_reg <= 1'b0;
                end
            endcase
        end
    end
endmodule

/* File: test/aes_card_bridge_monitor.sv */
`include "aes_card_cfg.svh"

module aes_card_bridge_monitor (
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic       io_cs_n,
    input wire logic [8:0] io_addr,
    input wire logic [7:0] io_data_out,
    input wire logic       io_data_oe,
    input wire logic [3:0] rx_cs_n,
    input wire logic [3:0] tx_cs_n,
    input wire logic       config_done,
    input wire logic       link_clk,
    input wire logic [2:0] octal_out,
    input wire logic [2:0] octal_out_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    // release of a select lags the strobe by the sync chain
    sequence bus_quiet;
        io_cs_n [*8];
    endsequence
    a_quiet_idle: assert property (@(posedge ref_clk) disable iff (rst)
        bus_quiet |-> rx_cs_n == 4'hf && tx_cs_n == 4'hf && !io_data_oe)
        else $error("drive with no bus request");
    a_early_quiet: assert property (@(posedge ref_clk) disable iff (rst)
        !config_done |-> !io_data_oe && rx_cs_n == 4'hf && tx_cs_n == 4'hf)
        else $error("bus answered before configuration");
    a_done_holds: assert property (@(posedge ref_clk) disable iff (rst)
        config_done |=> config_done)
        else $error("config_done dropped");
    a_rx_one_sel: assert property (@(posedge ref_clk) disable iff (rst)
        rx_cs_n != 4'hf |-> tx_cs_n == 4'hf && rx_cs_n[io_addr[6:5]] == 1'b0 && $onehot(~rx_cs_n))
        else $error("receiver select wrong");
    a_tx_one_sel: assert property (@(posedge ref_clk) disable iff (rst)
        $onehot(~tx_cs_n) |-> io_addr[8:7] == 2'h3 && tx_cs_n[io_addr[6:5]] == 1'b0)
        else $error("transmitter select wrong");
    a_tx_all_addr: assert property (@(posedge ref_clk) disable iff (rst)
        tx_cs_n == 4'h0 |-> io_addr[8:5] == 4'h3)
        else $error("global select at wrong offset");
    a_chip_no_drive: assert property (@(posedge ref_clk) disable iff (rst)
        (rx_cs_n != 4'hf || tx_cs_n != 4'hf) |-> !io_data_oe)
        else $error("read data driven during chip access");
    a_id_fixed: assert property (@(posedge ref_clk) disable iff (rst)
        io_data_oe && io_addr == `OFS_ID |-> io_data_out == `BOARD_ID_VALUE)
        else $error("identity value wrong");
    a_lock_unused: assert property (@(posedge ref_clk) disable iff (rst)
        io_data_oe && io_addr == `OFS_LOCK |-> io_data_out[7:2] == 6'h00)
        else $error("lock unused bits not zero");
    a_oct_unused: assert property (@(posedge ref_clk) disable iff (rst)
        io_data_oe && io_addr == `OFS_OCT_SEL |-> io_data_out[7:5] == 3'h0)
        else $error("octal select unused bits not zero");
    a_link_mask: assert property (@(posedge link_clk) disable iff (rst)
        (octal_out & ~octal_out_oe) == 3'h0)
        else $error("octal line driven while disabled");
endmodule

/* File: test/host_link_model.sv */
module host_link_model (
    input  wire logic       link_clk,
    input  wire logic [2:0] line_level,
    output logic            link_fsync,
    output logic      [2:0] octal_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] pos_reg = 8'h00;
    initial link_fsync = 1'b0;
    initial octal_in = 3'h0;
    // frame start once every 256 link clocks
    always @(posedge link_clk)
    begin
        pos_reg <= #1 pos_reg + 8'h01;
        link_fsync <= #1 (pos_reg == 8'hff);
        octal_in <= #1 line_level;
    end
endmodule

/* File: test/tb_top.sv */
`include "aes_card_cfg.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, rst = 1'b1, link_clk = 1'b0;
    logic io_cs_n = 1'b1, io_rd_n = 1'b1, io_wr_n = 1'b1;
    logic [8:0] io_addr = 9'h000;
    logic [7:0] io_data_in = 8'h00, io_data_out, q, v, sel;
    logic [1:0] stb;
    logic io_data_oe, chip_rd_n, chip_wr_n, mem_clk, mem_data, config_done;
    logic [3:0] rx_cs_n, tx_cs_n, rx_word_clk = 4'h0, rx_sdata = 4'h0, tx_sdata;
    logic slot_word_clk, preview_word_clk, double_speed, seek_mode, drive_rx_clocks;
    logic link_fsync, i2s_bclk, i2s_lrck;
    logic [2:0] octal_in, octal_out, octal_out_oe, line_level = 3'h0;
    logic [5:0] cfg_bit = 6'h00;
    logic [31:0] rng = 32'd89403;
    int n_fail = 0, n_compared = 0, cyc = 0;

    always #20 ref_clk = ~ref_clk;
    initial
    begin
        #3.3;
        forever #6 link_clk = ~link_clk;
    end
    // bits move on the falling clock; reset pins the count
    always @(negedge mem_clk) cfg_bit <= rst ? 6'h00 : cfg_bit + 6'h01;
    assign mem_data = (cfg_bit < 6'h08) ? `CFG_SYNC >> (7 - cfg_bit) : 1'b0;

    aes_card_bridge dut (.ref_clk, .rst, .io_cs_n, .io_rd_n, .io_wr_n, .io_addr, .io_data_in, .io_data_out,
        .io_data_oe, .rx_cs_n, .tx_cs_n, .chip_rd_n, .chip_wr_n, .serial_config_memory_clk(mem_clk),
        .serial_config_memory_data(mem_data), .config_done, .rx_word_clk, .slot_word_clk, .preview_word_clk,
        .double_speed, .seek_mode, .drive_rx_clocks, .link_clk, .link_fsync, .octal_in, .octal_out,
        .octal_out_oe, .i2s_bclk, .i2s_lrck, .rx_sdata, .tx_sdata);
    host_link_model host (.link_clk, .line_level, .link_fsync, .octal_in);

    function automatic logic [7:0] next_rand();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng[7:0];
    endfunction
    function automatic logic [7:0] rd_mask(input logic [8:0] a);
        return (a == `OFS_LOCK) ? 8'h03 : (a == `OFS_OCT_SEL) ? 8'h1f : 8'hff;
    endfunction

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // strobes held well past the sync delay
    task automatic bus(input logic wr, input logic [8:0] a, input logic [7:0] d);
        q = 8'h00;
        io_addr = a;
        io_data_in = d;
        io_cs_n = 1'b0;
        io_wr_n = !wr;
        io_rd_n = wr;
        for (int i = 0; i < 12; i++)
        begin
            step(1);
            if (io_data_oe === 1'b1) q = io_data_out;
            if (i == 8) {sel, stb} = {rx_cs_n, tx_cs_n, chip_rd_n, chip_wr_n};
        end
        io_cs_n = 1'b1;
        io_rd_n = 1'b1;
        io_wr_n = 1'b1;
        step(8);
    endtask
    task automatic link_run(input logic [3:0] rx, input logic [2:0] lvl, input logic [7:0] exp);
        logic [7:0] hi = 8'hff, lo = 8'h00;
        @(posedge link_clk);
        #1;
        rx_sdata = rx;
        line_level = lvl;
        repeat (768) @(posedge link_clk);
        repeat (256)
        begin
            @(posedge link_clk);
            #1;
            hi = hi & {i2s_lrck, octal_out, tx_sdata};
            lo = lo | {i2s_lrck, octal_out, tx_sdata};
        end
        check("link low", hi, exp);
        check("link high", lo, exp | 8'h80);
        step(1);
    endtask
    task automatic report_and_stop();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            report_and_stop();
        end
    end

    initial
    begin
        step(20);
        rst = 1'b0;
        bus(1'b1, `OFS_CTRL, 8'hff); // ignored, card not configured yet
        for (int i = 0; i < 2000 && config_done !== 1'b1; i++) step(1);
        check("config_done", config_done, 1'b1);
        bus(1'b0, `OFS_CTRL, 8'h00);
        check("ctrl after reset", q, 8'h00);
        bus(1'b0, `OFS_LOCK, 8'h00);
        check("lock after reset", q, 8'h00);
        bus(1'b0, `OFS_OCT_SEL, 8'h00);
        check("octal after reset", q, 8'h00);
        check("modes after reset", {double_speed, seek_mode, drive_rx_clocks}, 8'h00);
        bus(1'b1, `OFS_ID, 8'h00);
        bus(1'b0, `OFS_ID, 8'h00);
        check("identity", q, `BOARD_ID_VALUE);
        for (int i = 0; i < 24; i++)
        begin
            io_addr = (i % 3 == 0) ? `OFS_CTRL : (i % 3 == 1) ? `OFS_LOCK : `OFS_OCT_SEL;
            v = (i < 3) ? 8'hff : next_rand();
            bus(1'b1, io_addr, v);
            bus(1'b0, io_addr, 8'h00);
            check("readback", q, v & rd_mask(io_addr));
            if (i % 3 == 0) check("double_speed", double_speed, v[1]);
            if (i % 3 == 1) check("lock bits", {seek_mode, drive_rx_clocks}, v[1:0]);
        end
        $display("register test done");
        for (int k = 0; k < 10; k++)
        begin
            v = (k < 8) ? 8'h08 + k : (k == 8) ? 8'h03 : 8'h05;
            bus(1'b0, {v[3:0], 5'h00}, 8'h00);
            check("chip data", q, 8'h00);
            check("chip strobes", stb, (k < 9) ? 8'h01 : 8'h03);
            if (k < 4) check("rx select", sel, {~(4'h1 << k), 4'hf});
            else if (k < 8) check("tx select", sel, {4'hf, ~(4'h1 << (k - 4))});
            else if (k == 8) check("tx all select", sel, 8'hf0);
            else check("unmapped select", sel, 8'hff);
        end
        $display("address map test done");
        for (int s = 0; s < 4; s++)
        begin
            v = {2'(s), 2'(3 - s), 4'hc};
            bus(1'b1, `OFS_CTRL, v);
            rx_word_clk = 4'h1 << s;
            step(8);
            check("word clocks high", {slot_word_clk, preview_word_clk}, 8'h02);
            rx_word_clk = ~(4'h1 << s);
            step(8);
            check("word clocks low", {slot_word_clk, preview_word_clk}, 8'h01);
            bus(1'b1, `OFS_CTRL, v & 8'hf0);
            rx_word_clk = 4'hf;
            step(8);
            check("word clocks off", {slot_word_clk, preview_word_clk}, 8'h00);
        end
        $display("word clock test done");
        bus(1'b1, `OFS_CTRL, 8'h00);
        for (int g = 0; g < 4; g++)
        begin
            bus(1'b1, `OFS_OCT_SEL, 8'h1c | g);
            link_run(4'hf, (g < 3) ? 3'h1 << g : 3'h7, (g < 3) ? 8'h7f : 8'h70);
        end
        bus(1'b1, `OFS_OCT_SEL, 8'h14);
        link_run(4'hf, 3'h6, 8'h50);
        check("octal enables", octal_out_oe, 3'h5);
        bus(1'b1, `OFS_OCT_SEL, 8'h1c);
        link_run(4'h0, 3'h6, 8'h00);
        bus(1'b1, `OFS_CTRL, 8'h01);
        link_run(4'hf, 3'h0, 8'h0f);
        link_run(4'h0, 3'h7, 8'h70);
        $display("link test done");
        report_and_stop();
    end
endmodule

bind aes_card_bridge aes_card_bridge_monitor mon (.ref_clk, .rst, .io_cs_n, .io_addr, .io_data_out, .io_data_oe,
    .rx_cs_n, .tx_cs_n, .config_done, .link_clk, .octal_out, .octal_out_oe);
